// [pkg/sdrpi_pkg.sv]
package sdrpi_pkg;
    localparam int          DATA_W         = 64;
    localparam int          MASK_W         = 8;
    localparam int          ADDR_W         = 13;
    localparam int          BANK_W         = 2;
    localparam int          ROWS           = 4;
    localparam int          CLKS_PER_ROW   = 2;
    localparam int          SCK_W          = 8;
    localparam int          CS_W           = 8;
    localparam int          DQS_W          = 8;
    localparam int          MEM_CLK_MHZ    = 133;
    localparam int          SYS_CLK_KHZ    = 25000;
    localparam int          IDLE_PD_NS     = 1000;
    localparam int          IDLE_PD_CYC    = (IDLE_PD_NS * SYS_CLK_KHZ)
                                             / 1000000;
    localparam int          CAP_DEPTH      = 4;
    localparam logic [0:0]  MEMORY_TYPE_STRAP_DDR     = 1'h0;
    localparam logic [0:0]  MEMORY_TYPE_STRAP_SDR     = 1'h1;

    // Command encodings on {row, col, write} strobes, active low.
    localparam logic [2:0]  CMD_NOP        = 3'h7;
    localparam logic [2:0]  CMD_ACT        = 3'h3;
    localparam logic [2:0]  CMD_READ       = 3'h5;
    localparam logic [2:0]  CMD_WRITE      = 3'h4;
    localparam logic [2:0]  CMD_PRE        = 3'h2;
    localparam logic [2:0]  CMD_REF        = 3'h1;
    localparam logic [2:0]  CMD_MRS        = 3'h0;

    typedef enum logic [3:0] {
        SDRPI_ST_STRAP  = 4'h1,
        SDRPI_ST_RUN    = 4'h2,
        SDRPI_ST_SELFR  = 4'h4,
        SDRPI_ST_DDR    = 4'h8
    } sdrpi_state_e;
endpackage

// [hdl/sdrpi_row_cke.sv]
`timescale 1ns/100ps
module sdrpi_row_cke #(
    parameter int IDLE_CYC = sdrpi_pkg::IDLE_PD_CYC
) (
    input  wire logic sys_clk,      // System clock.
    input  wire logic rstn,         // Synchronous reset, active low.
    input  wire logic enable,       // Row power management allowed.
    input  wire logic hit,          // Row addressed this cycle.
    input  wire logic suspend,      // Force self-refresh.
    output logic      cke           // Row clock enable.
);
    import sdrpi_pkg::*;

    initial begin
        if (IDLE_CYC < 1 || IDLE_CYC > 65535) begin
            $error("IDLE_CYC must lie between one and 65535");
        end
    end

    typedef struct packed {
        logic [15:0] idle;
        logic        cke;
    } sdrpi_cke_s;

    sdrpi_cke_s st_reg;
    sdrpi_cke_s st_next;

    always_comb begin
        st_next = st_reg;
        if (!enable || suspend) begin
            st_next.cke  = 1'b0;
            st_next.idle = 16'h0000;
        end else if (hit) begin
            st_next.cke  = 1'b1;
            st_next.idle = 16'h0000;
        end else if (st_next.idle >= 16'(IDLE_CYC - 1)) begin
            st_next.cke = 1'b0;
        end else begin
            st_next.idle = st_reg.idle + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cke = st_reg.cke;
endmodule

// [hdl/sdrpi_top.sv]
`timescale 1ns/100ps
module sdrpi_top #(
    parameter int IDLE_CYC = sdrpi_pkg::IDLE_PD_CYC
) (
    input  wire logic                         sys_clk,      // Memory clock.
    input  wire logic                         rstn,         // Power-up reset.
    input  wire logic                         memory_type_strap, // Strap pin.
    input  wire logic                         suspend_req,  // Enter suspend.
    input  wire logic                         cmd_valid,    // Command request.
    input  wire logic [2:0]                   cmd_code,     // Strobe code.
    input  wire logic [1:0]                   cmd_row,      // Target row.
    input  wire logic                         cmd_side,     // Chip select half.
    input  wire logic [sdrpi_pkg::ADDR_W-1:0] cmd_addr,     // Row/col address.
    input  wire logic [sdrpi_pkg::BANK_W-1:0] cmd_bank,     // Bank.
    input  wire logic [sdrpi_pkg::DATA_W-1:0] wr_data,      // Write data.
    input  wire logic [sdrpi_pkg::MASK_W-1:0] wr_mask,      // Write byte mask.
    input  wire logic                         rd_expect,    // Read data due.
    output logic                              sdr_mode,     // SDR selected.
    output logic                              ready,        // Accepts command.
    output logic [sdrpi_pkg::DATA_W-1:0]      rd_data,      // Read data.
    output logic                              rd_valid,     // Read data pulse.
    output logic [sdrpi_pkg::SCK_W-1:0]       sdram_clk,    // SDRAM clocks.
    output logic [sdrpi_pkg::CS_W-1:0]        row_chip_select_n, // Selects.
    output logic [sdrpi_pkg::ADDR_W-1:0]      mem_row_col_addr, // Address.
    output logic [sdrpi_pkg::BANK_W-1:0]      bank_select,  // Bank select.
    output logic                              row_strobe_n, // Row strobe.
    output logic                              col_strobe_n, // Column strobe.
    output logic                              write_strobe_n, // Write strobe.
    input  wire logic [sdrpi_pkg::DATA_W-1:0] mem_data_lines_i, // Data in.
    output logic [sdrpi_pkg::DATA_W-1:0]      mem_data_lines_o, // Data out.
    output logic                              mem_data_lines_oe, // Data drive.
    output logic [sdrpi_pkg::MASK_W-1:0]      byte_write_mask, // Byte masks.
    output logic [sdrpi_pkg::ROWS-1:0]        row_clock_en, // Row CKEs.
    output logic                              read_clock_feedback_out, // Fb.
    input  wire logic                         read_clock_feedback_in, // Fb in.
    input  wire logic [sdrpi_pkg::DQS_W-1:0]  ddr_data_strobe_i, // Strobe in.
    output logic [sdrpi_pkg::DQS_W-1:0]       ddr_data_strobe_o, // Strobe out.
    output logic [sdrpi_pkg::DQS_W-1:0]       ddr_data_strobe_oe, // Drive.
    output logic                              ddr_diff_clock // DDR clock.
);
    import sdrpi_pkg::*;

    initial begin
        if (ROWS * CLKS_PER_ROW != SCK_W || CS_W != 2 * ROWS) begin
            $error("row, clock and select counts disagree");
        end
    end

    // The strap and feedback pins pass two flops first; read data is sampled directly.
    typedef struct packed {
        sdrpi_state_e           state;
        logic                   mode_sdr;
        logic [1:0]             strap_sync;
        logic [1:0]             fb_sync;
        logic                   fb_prev;
        logic                   rd_pend;
        logic [DATA_W-1:0]      rd_data;
        logic                   rd_valid;
        logic [CS_W-1:0]        cs_n;
        logic [ADDR_W-1:0]      addr;
        logic [BANK_W-1:0]      bank;
        logic [2:0]             cmd;
        logic [DATA_W-1:0]      dq_o;
        logic                   dq_oe;
        logic [MASK_W-1:0]      dm;
        logic                   fb_out;
    } sdrpi_top_s;

    sdrpi_top_s st_reg;
    sdrpi_top_s st_next;

    logic [ROWS-1:0] row_hit;
    logic            run_sdr;
    logic            in_suspend;
    logic            fb_rise;
    logic [2:0]      row_cs_bits;

    assign run_sdr    = (st_reg.state == SDRPI_ST_RUN);
    assign in_suspend = (st_reg.state == SDRPI_ST_SELFR);
    assign fb_rise    = st_reg.fb_sync[1] && !st_reg.fb_prev;
    assign row_cs_bits = {1'b0, cmd_row} * 3'h2;

    always_comb begin
        st_next          = st_reg;
        st_next.rd_valid = 1'b0;
        st_next.cs_n     = '1;
        st_next.cmd      = CMD_NOP;
        st_next.dq_oe    = 1'b0;
        st_next.dm       = '0;
        st_next.strap_sync = {st_reg.strap_sync[0], memory_type_strap};
        st_next.fb_sync  = {st_reg.fb_sync[0], read_clock_feedback_in};
        st_next.fb_prev  = st_reg.fb_sync[1];
        unique case (st_reg.state)
            SDRPI_ST_STRAP: begin
                // Captured once after reset release, then frozen.
                st_next.mode_sdr = (st_reg.strap_sync[1] == MEMORY_TYPE_STRAP_SDR);
                st_next.state    = (st_reg.strap_sync[1] == MEMORY_TYPE_STRAP_SDR)
                                   ? SDRPI_ST_RUN : SDRPI_ST_DDR;
            end
            SDRPI_ST_RUN: begin
                if (suspend_req) begin
                    st_next.state = SDRPI_ST_SELFR;
                    st_next.cs_n  = '0;
                    st_next.cmd   = CMD_REF;
                end else if (cmd_valid) begin
                    st_next.cs_n[row_cs_bits + {2'h0, cmd_side}] = 1'b0;
                    st_next.cmd  = cmd_code;
                    st_next.addr = cmd_addr;
                    st_next.bank = cmd_bank;
                    if (cmd_code == CMD_WRITE) begin
                        st_next.dq_o  = wr_data;
                        st_next.dq_oe = 1'b1;
                        st_next.dm    = wr_mask;
                    end
                end
                if (rd_expect) begin
                    st_next.rd_pend = 1'b1;
                end
                // Read data is taken on the returned feedback edge.
                if (st_reg.rd_pend && fb_rise) begin
                    st_next.rd_data  = mem_data_lines_i;
                    st_next.rd_valid = 1'b1;
                    st_next.rd_pend  = rd_expect;
                end
                st_next.fb_out = ~st_reg.fb_out;
            end
            SDRPI_ST_SELFR: begin
                if (!suspend_req) begin
                    st_next.state = SDRPI_ST_RUN;
                end
            end
            SDRPI_ST_DDR: begin
                // DDR signalling is handled elsewhere; stay parked.
                st_next.state = SDRPI_ST_DDR;
            end
            default: begin
                st_next.state = SDRPI_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            // The strap synchroniser keeps filling through reset, so the
            // first edge after release already sees the settled strap.
            st_reg            <= '0;
            st_reg.strap_sync <= {st_reg.strap_sync[0], memory_type_strap};
            st_reg.state      <= SDRPI_ST_STRAP;
            st_reg.cs_n  <= '1;
            st_reg.cmd   <= CMD_NOP;
        end else begin
            st_reg <= st_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < ROWS; g++) begin : g_row
            assign row_hit[g] = run_sdr && cmd_valid &&
                                (cmd_row == 2'(g));
            sdrpi_row_cke #(
                .IDLE_CYC (IDLE_CYC)
            ) u_cke (
                .sys_clk (sys_clk),
                .rstn    (rstn),
                .enable  (st_reg.mode_sdr),
                .hit     (row_hit[g]),
                .suspend (in_suspend || (run_sdr && suspend_req)),
                .cke     (row_clock_en[g])
            );
        end
    endgenerate

    // The SDRAM clocks follow the memory clock, gated off outside SDR.
    assign sdram_clk = st_reg.mode_sdr ? {SCK_W{sys_clk}} : '0;
    assign sdr_mode                = st_reg.mode_sdr;
    assign ready                   = run_sdr && !suspend_req;
    assign rd_data                 = st_reg.rd_data;
    assign rd_valid                = st_reg.rd_valid;
    assign row_chip_select_n       = st_reg.cs_n;
    assign mem_row_col_addr        = st_reg.addr;
    assign bank_select             = st_reg.bank;
    assign row_strobe_n            = st_reg.cmd[2];
    assign col_strobe_n            = st_reg.cmd[1];
    assign write_strobe_n          = st_reg.cmd[0];
    assign mem_data_lines_o        = st_reg.dq_o;
    assign mem_data_lines_oe       = st_reg.dq_oe;
    assign byte_write_mask         = st_reg.dm;
    assign read_clock_feedback_out = st_reg.fb_out;
    assign ddr_data_strobe_o       = '0;
    assign ddr_data_strobe_oe      = '0;
    assign ddr_diff_clock          = 1'b0;
endmodule

// [verif/sdrpi_assertions.sv]
`timescale 1ns/100ps
module sdrpi_assertions #(
    parameter int IDLE_CYC = sdrpi_pkg::IDLE_PD_CYC
) (
    input wire logic        sys_clk, rstn, suspend_req, cmd_valid,
    input wire logic        cmd_side, sdr_mode, ready, row_strobe_n,
    input wire logic        col_strobe_n, write_strobe_n, ddr_diff_clock,
    input wire logic        mem_data_lines_oe,
    input wire logic [1:0]  cmd_row, cmd_bank, bank_select,
    input wire logic [2:0]  cmd_code,
    input wire logic [3:0]  row_clock_en,
    input wire logic [7:0]  wr_mask, sdram_clk, row_chip_select_n,
    input wire logic [7:0]  byte_write_mask, ddr_data_strobe_oe,
    input wire logic [12:0] cmd_addr, mem_row_col_addr,
    input wire logic [63:0] wr_data, mem_data_lines_o
);
    import sdrpi_pkg::*;
    logic [7:0] idle_reg;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Refused requests also clear the count, so the bound stays safe.
    always_ff @(posedge sys_clk) begin
        if (!rstn || cmd_valid || suspend_req || !sdr_mode)
            idle_reg <= 8'h00;
        else if (idle_reg != 8'hFF)
            idle_reg <= idle_reg + 8'h01;
    end
    sequence s_issue;
        cmd_valid && ready;
    endsequence
    sequence s_lone;
        s_issue ##1 (!cmd_valid && !suspend_req);
    endsequence
    AST_CMD_PINS: assert property (s_issue |=>
        row_chip_select_n == ~(8'h01 << $past({cmd_row, cmd_side})) &&
        {row_strobe_n, col_strobe_n, write_strobe_n} == $past(cmd_code))
        else $error("command pins wrong");
    AST_ADDR_BANK: assert property (s_issue |=>
        mem_row_col_addr == $past(cmd_addr) &&
        bank_select == $past(cmd_bank)) else $error("address wrong");
    AST_WRITE_DRIVE: assert property (
        s_issue ##0 cmd_code == CMD_WRITE |=> mem_data_lines_oe &&
        mem_data_lines_o == $past(wr_data) &&
        byte_write_mask == $past(wr_mask)) else $error("write wrong");
    AST_ONE_CYCLE: assert property (s_lone |=>
        row_chip_select_n == 8'hFF && !mem_data_lines_oe)
        else $error("command held too long");
    AST_SUSPEND: assert property ($rose(suspend_req) && $past(ready)
        |=> row_clock_en == 4'h0 && row_chip_select_n == 8'h00)
        else $error("self-refresh entry wrong");
    AST_WAKE: assert property (s_issue |=>
        row_clock_en[$past(cmd_row)]) else $error("row not woken");
    AST_IDLE_PD: assert property (idle_reg > IDLE_CYC + 3 |->
        row_clock_en == 4'h0) else $error("idle rows not down");
    AST_MODE_FIXED: assert property ($past(ready) |->
        $stable(sdr_mode)) else $error("memory type changed");
    AST_SCK_OFF: assert property (!sdr_mode |->
        sdram_clk == 8'h00) else $error("clocks run in DDR mode");
    AST_DDR_IDLE: assert property (ddr_data_strobe_oe == 8'h00
        && !ddr_diff_clock) else $error("DDR pins active");
endmodule
bind sdrpi_top sdrpi_assertions #(.IDLE_CYC(IDLE_CYC)) u_chk (
    .sys_clk, .rstn, .suspend_req, .cmd_valid, .cmd_side, .sdr_mode,
    .ready, .row_strobe_n, .col_strobe_n, .write_strobe_n,
    .ddr_diff_clock, .mem_data_lines_oe, .cmd_row, .cmd_bank,
    .bank_select, .cmd_code, .row_clock_en, .wr_mask, .sdram_clk,
    .row_chip_select_n, .byte_write_mask, .ddr_data_strobe_oe,
    .cmd_addr, .mem_row_col_addr, .wr_data, .mem_data_lines_o);

// [verif/sdrpi_mem_model.sv]
`timescale 1ns/100ps
module sdrpi_mem_model (
    input  wire logic [7:0]  sck,     // Module clocks.
    input  wire logic [7:0]  cs_n,    // Chip selects.
    input  wire logic [2:0]  cmd,     // Strobe code.
    input  wire logic [63:0] rd_word, // Word to return.
    output logic      [63:0] dq,      // Data to controller.
    output logic             fb       // Returned read clock.
);
    import sdrpi_pkg::*;
    initial begin
        dq = 64'h0;
        fb = 1'b0;
    end
    // A read seen while busy is dropped; the released bus shows the
    // inverse of the last word so stale data can never pass.
    always @(posedge sck[0]) begin
        if (cs_n != 8'hFF && cmd == CMD_READ) begin
            // Edges land clear of the rising clock edges so the controller never samples a race.
            #20 dq = rd_word;
            #150 fb = 1'b1;
            #160 fb = 1'b0;
            #320 dq = ~dq;
        end
    end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import sdrpi_pkg::*;
    localparam int IDLE = 2;
    logic        sys_clk = '0, rstn = '0, memory_type_strap = '0;
    logic        suspend_req = '0, cmd_valid = '0, cmd_side = '0;
    logic        rd_expect = '0, sdr_mode, ready, rd_valid, row_strobe_n;
    logic        col_strobe_n, write_strobe_n, mem_data_lines_oe;
    logic        read_clock_feedback_out, ddr_diff_clock;
    logic        read_clock_feedback_in;
    logic [1:0]  cmd_row = '0, cmd_bank = '0, bank_select;
    logic [2:0]  cmd_code = '0;
    logic [3:0]  row_clock_en;
    logic [7:0]  wr_mask = '0, ddr_data_strobe_i = '0, sdram_clk;
    logic [7:0]  row_chip_select_n, byte_write_mask, ddr_data_strobe_o;
    logic [7:0]  ddr_data_strobe_oe;
    logic [12:0] cmd_addr = '0, mem_row_col_addr;
    logic [31:0] seed = 32'h6, x;
    logic [63:0] wr_data = '0, rd_word = '0, rd_data, mem_data_lines_o;
    logic [63:0] mdq;
    wire  [63:0] mem_data_lines_i = mem_data_lines_oe ? mem_data_lines_o
                                                      : mdq;
    int          errors = 0, n_tests = 0, cyc = 0, i;
    sdrpi_top #(.IDLE_CYC(IDLE)) DUT (.sys_clk, .rstn, .memory_type_strap,
        .suspend_req, .cmd_valid, .cmd_code, .cmd_row, .cmd_side,
        .cmd_addr, .cmd_bank, .wr_data, .wr_mask, .rd_expect, .sdr_mode,
        .ready, .rd_data, .rd_valid, .sdram_clk, .row_chip_select_n,
        .mem_row_col_addr, .bank_select, .row_strobe_n, .col_strobe_n,
        .write_strobe_n, .mem_data_lines_i, .mem_data_lines_o,
        .mem_data_lines_oe, .byte_write_mask, .row_clock_en,
        .read_clock_feedback_out, .read_clock_feedback_in,
        .ddr_data_strobe_i, .ddr_data_strobe_o, .ddr_data_strobe_oe,
        .ddr_diff_clock);
    sdrpi_mem_model MEM (.sck(sdram_clk), .cs_n(row_chip_select_n),
        .cmd({row_strobe_n, col_strobe_n, write_strobe_n}),
        .rd_word(rd_word), .dq(mdq), .fb(read_clock_feedback_in));
    always #20 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_cs(input logic [1:0] r,
                                          input logic s);
        return ~(8'h01 << {r, s});
    endfunction
    task automatic report_and_stop();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic s);
        memory_type_strap = s;
        rstn = 1'b0;
        repeat (20) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask
    // Entered at a falling edge with ready high; leaves one idle cycle.
    task automatic issue(input logic [2:0] c, input logic [1:0] r,
                         input logic s);
        x = rnd();
        {cmd_valid, cmd_code, cmd_row, cmd_side} = {1'b1, c, r, s};
        {cmd_bank, cmd_addr, wr_mask} = x[22:0];
        wr_data = {rnd(), rnd()};
        rd_expect = (c == CMD_READ);
        @(negedge sys_clk);
        {cmd_valid, rd_expect} = 2'h0;
        chk(row_chip_select_n, exp_cs(r, s));
        chk({row_strobe_n, col_strobe_n, write_strobe_n}, c);
        chk({bank_select, mem_row_col_addr}, {cmd_bank, cmd_addr});
        chk(row_clock_en[r], 1'b1);
        if (c == CMD_WRITE) begin
            chk(mem_data_lines_o, wr_data);
            chk({mem_data_lines_oe, byte_write_mask}, {1'b1, wr_mask});
        end
        @(negedge sys_clk);
        chk(row_chip_select_n, 8'hFF);
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        do_reset(1'b0);
        chk(sdr_mode, MEMORY_TYPE_STRAP_DDR);
        cmd_valid = 1'b1;
        repeat (2) @(negedge sys_clk);
        cmd_valid = 1'b0;
        chk({row_chip_select_n, sdram_clk}, 16'hFF00);
        do_reset(1'b1);
        chk(sdr_mode, MEMORY_TYPE_STRAP_SDR);
        #21 chk(sdram_clk, 8'hFF);
        @(negedge sys_clk);
        x[0] = read_clock_feedback_out;
        @(negedge sys_clk);
        chk(read_clock_feedback_out, !x[0]);
        rd_word = {rnd(), rnd()};
        issue(CMD_READ, 2'h1, 1'b0);
        for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge sys_clk);
        chk({rd_valid, rd_data}, {1'b1, rd_word});
        repeat (IDLE + 24) @(negedge sys_clk);
        chk(row_clock_en, 4'h0);
        for (i = 0; i < 24; i++) issue(3'(i), seed[1:0], seed[2]);
        {suspend_req, cmd_valid} = 2'h3;
        @(negedge sys_clk);
        chk({ready, row_clock_en, row_chip_select_n}, 13'h0);
        repeat (3) @(negedge sys_clk);
        chk({row_clock_en, row_chip_select_n}, 12'h0FF);
        {suspend_req, cmd_valid, memory_type_strap} = 3'h0;
        for (i = 0; i < 20 && ready !== 1'b1; i++) @(negedge sys_clk);
        chk({ready, sdr_mode, ddr_data_strobe_oe}, 10'h300);
        issue(CMD_WRITE, 2'h3, 1'b1);
        report_and_stop();
    end
endmodule
